// File: core/swcfg_defines.svh
// Constants of the switch configuration register set and its serial frame.
//Contract
//[R1] D12-D14 select register; D15 is watchdog service
//[R2] Output command bit high switches output on
//[R3] Direct enable bit low grants pin control
//[R4] Combine bit high ANDs, low ORs pin
//[R5] D5:D4 pick timeout divide 1, 2, 4, 8
//[R6] Master toggles service bit when changing timeout
//[R7] Sense bits route high-side current to pairs
//[R8] High-side open-load bit high disables detection
//[R9] Low-side open-load bit high enables detection
//[R10] High-side limit bit selects sustain current level
//[R11] Low-side limit bit enables over-current latch-off
//[R12] Address high-high-low writes have no effect
//[R13] Test address writes are never accepted
//[R14] Status loads at select fall, shifts MSB first
//[R15] First status bit echoes last output-command service
//[R16] Next three bits report pins chosen by echo
//[R17] Low twelve bits report per-output latched faults
//[R18] After sixteen bits, received bits are echoed
//[R19] Latch only frames of whole sixteen-bit multiples
//[R20] Select rise floats output, releases fault capture
//[R21] Configuration reads as all zero after reset
`ifndef SWCFG_DEFINES_SVH
`define SWCFG_DEFINES_SVH

`define SWCFG_FRAME_BITS 16
`define SWCFG_DATA_BITS 12
`define SWCFG_HS_COUNT 4
`define SWCFG_LS_COUNT 8
`define SWCFG_PIN_COUNT 7
`define SWCFG_RISE_MAX 5'h10
`define SWCFG_LAST_FALL 4'hF

`define SWCFG_ADDR_OUT_CMD 3'h0
`define SWCFG_ADDR_OPEN_LOAD 3'h1
`define SWCFG_ADDR_COMBINE 3'h2
`define SWCFG_ADDR_UNUSED 3'h3
`define SWCFG_ADDR_DIRECT_EN 3'h4
`define SWCFG_ADDR_CUR_LIMIT 3'h5
`define SWCFG_ADDR_WDOG_SENSE 3'h6
`define SWCFG_ADDR_TEST 3'h7

`define SWCFG_SENSE_A_LSB 0
`define SWCFG_SENSE_B_LSB 2
`define SWCFG_WDT_LSB 4
`define SWCFG_CFG_RESET 12'h000
`define SWCFG_HS_OL_RESET 4'hF

`endif

// File: core/swcfg_pkg.sv
// Types shared by the switch configuration block.
`include "swcfg_defines.svh"
package swcfg_pkg;

    typedef enum logic [2:0] {
        SWCFG_ADDR_OUT_CMD = `SWCFG_ADDR_OUT_CMD,
        SWCFG_ADDR_OPEN_LOAD = `SWCFG_ADDR_OPEN_LOAD,
        SWCFG_ADDR_COMBINE = `SWCFG_ADDR_COMBINE,
        SWCFG_ADDR_UNUSED = `SWCFG_ADDR_UNUSED,
        SWCFG_ADDR_DIRECT_EN = `SWCFG_ADDR_DIRECT_EN,
        SWCFG_ADDR_CUR_LIMIT = `SWCFG_ADDR_CUR_LIMIT,
        SWCFG_ADDR_WDOG_SENSE = `SWCFG_ADDR_WDOG_SENSE,
        SWCFG_ADDR_TEST = `SWCFG_ADDR_TEST
    } swcfg_addr_t;

    typedef enum logic [1:0] {
        SWCFG_WDT_DIV1 = 2'h0,
        SWCFG_WDT_DIV2 = 2'h1,
        SWCFG_WDT_DIV4 = 2'h2,
        SWCFG_WDT_DIV8 = 2'h3
    } swcfg_wdt_div_t;

    typedef struct packed {
        logic service;
        swcfg_addr_t addr;
        logic [`SWCFG_DATA_BITS-1:0] data;
    } swcfg_frame_t;

    typedef struct packed {
        logic wd_echo;
        logic [2:0] pin_state;
        logic [`SWCFG_DATA_BITS-1:0] fault;
    } swcfg_status_t;

    typedef struct packed {
        logic [`SWCFG_DATA_BITS-1:0] out_cmd;
        logic [`SWCFG_DATA_BITS-1:0] direct_en;
        logic [`SWCFG_DATA_BITS-1:0] combine;
        logic [`SWCFG_DATA_BITS-1:0] wdog_sense;
        logic [`SWCFG_DATA_BITS-1:0] open_load;
        logic [`SWCFG_DATA_BITS-1:0] cur_limit;
    } swcfg_cfg_t;

endpackage : swcfg_pkg

// File: core/swcfg_top.sv
// Serial configuration registers and status word of the smart switch.
`timescale 1ns/1ps
`include "swcfg_defines.svh"
module swcfg_top (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic SPI_SCLK,
    input wire logic CHIP_SELECT_N,
    input wire logic SPI_SI,
    output logic SPI_SO,
    output logic SPI_SO_OE,
    input wire logic [`SWCFG_HS_COUNT-1:0] HIGH_SIDE_DIRECT_IN,
    input wire logic LOW_SIDE_DIRECT_IN,
    input wire logic FAILSAFE_DISABLE_PIN,
    input wire logic WAKE_PIN,
    input wire logic [`SWCFG_DATA_BITS-1:0] OUTPUT_FAULT,
    output logic [`SWCFG_HS_COUNT-1:0] HIGH_SIDE_OUTPUT,
    output logic [`SWCFG_LS_COUNT-1:0] LOW_SIDE_OUTPUT,
    output logic [1:0] SENSE_OUT_PAIR_A_ROUTE,
    output logic [1:0] SENSE_OUT_PAIR_B_ROUTE,
    output swcfg_pkg::swcfg_wdt_div_t WDOG_TIMEOUT_DIV,
    output logic WATCHDOG_SERVICE_BIT,
    output logic [`SWCFG_HS_COUNT-1:0] HS_OPEN_LOAD_EN,
    output logic [`SWCFG_LS_COUNT-1:0] LS_OPEN_LOAD_EN,
    output logic [`SWCFG_HS_COUNT-1:0] HS_SUSTAIN_LIMIT,
    output logic [`SWCFG_LS_COUNT-1:0] LS_LATCH_OFF_EN
);

    // Direct pin blended with the serial command for one output
    function automatic logic drive_bit(input logic cmd, input logic direct_off,
                                       input logic use_and, input logic pin);
        logic res;
        res = cmd;
        if (!direct_off) begin // [R3]
            res = use_and ? (pin & cmd) : (pin | cmd); // [R4]
        end
        return res;
    endfunction : drive_bit

    // ---------------- Link domain (shift clock) ----------------
    // Select high holds the frame counters in reset; the shift clock is
    // expected to be idle then, so nothing here needs an edge outside a frame.
    logic link_rst;
    logic [3:0] fall_cnt;
    logic first_seen;
    logic frame_tog;
    logic [`SWCFG_FRAME_BITS-1:0] rx_shift;
    swcfg_pkg::swcfg_frame_t frame_word;
    logic frame_ok;
    logic [4:0] rise_cnt;
    logic so_shift;
    swcfg_pkg::swcfg_status_t status_word;
    logic [`SWCFG_FRAME_BITS-1:0] status_bits;

    assign link_rst = RST | CHIP_SELECT_N;
    assign status_bits = status_word;

    always_ff @(negedge SPI_SCLK or posedge link_rst) begin
        if (link_rst) begin
            fall_cnt <= 4'h0;
        end else begin
            fall_cnt <= fall_cnt + 4'h1;
        end
    end

    always_ff @(negedge SPI_SCLK or posedge link_rst) begin
        if (link_rst) begin
            first_seen <= 1'b0;
        end else begin
            first_seen <= 1'b1;
        end
    end

    // Flips once per frame that saw at least one clock, so an empty frame is dropped
    always_ff @(negedge SPI_SCLK or posedge RST) begin
        if (RST) begin
            frame_tog <= 1'b0;
        end else if (!first_seen) begin
            frame_tog <= ~frame_tog;
        end
    end

    always_ff @(negedge SPI_SCLK or posedge RST) begin
        if (RST) begin
            rx_shift <= 16'h0000;
        end else begin
            rx_shift <= {rx_shift[`SWCFG_FRAME_BITS-2:0], SPI_SI};
        end
    end

    // Last sixteen bits and the length check survive select rise for the core side
    always_ff @(negedge SPI_SCLK or posedge RST) begin
        if (RST) begin
            frame_word <= '0;
            frame_ok <= 1'b0;
        end else begin
            frame_word <= {rx_shift[`SWCFG_FRAME_BITS-2:0], SPI_SI}; // [R1]
            frame_ok <= (fall_cnt == `SWCFG_LAST_FALL); // [R19]
        end
    end

    always_ff @(posedge SPI_SCLK or posedge link_rst) begin
        if (link_rst) begin
            rise_cnt <= 5'h00;
        end else if (rise_cnt != `SWCFG_RISE_MAX) begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end

    // The status word is frozen on the core side for the whole frame,
    // so reading it here is safe once select has led the clock by 3 core cycles.
    always_ff @(posedge SPI_SCLK or posedge link_rst) begin
        if (link_rst) begin
            so_shift <= 1'b0;
        end else if (rise_cnt < `SWCFG_RISE_MAX) begin
            so_shift <= status_bits[4'hF - rise_cnt[3:0]]; // [R14]
        end else begin
            so_shift <= rx_shift[`SWCFG_FRAME_BITS-1]; // [R18]
        end
    end

    // The first bit must stand before any clock edge, hence the bypass
    assign SPI_SO = (rise_cnt == 5'h00) ? status_word.wd_echo : so_shift; // [R15]
    assign SPI_SO_OE = ~CHIP_SELECT_N; // [R20]

    // ---------------- Core domain (REF_CLK) ----------------
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic [`SWCFG_PIN_COUNT-1:0] pin_meta;
    logic [`SWCFG_PIN_COUNT-1:0] pin_sync;
    logic [`SWCFG_DATA_BITS-1:0] fault_meta;
    logic [`SWCFG_DATA_BITS-1:0] fault_sync;
    logic [`SWCFG_DATA_BITS-1:0] fault_latch;
    logic cs_rise;
    logic commit;
    logic wd_echo;
    logic wrote_any;
    logic [2:0] next_pins;
    swcfg_pkg::swcfg_cfg_t cfg;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= CHIP_SELECT_N;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
        end else begin
            tog_meta <= frame_tog;
            tog_sync <= tog_meta;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pin_meta <= '0;
            pin_sync <= '0;
            fault_meta <= '0;
            fault_sync <= '0;
        end else begin
            pin_meta <= {WAKE_PIN, FAILSAFE_DISABLE_PIN, LOW_SIDE_DIRECT_IN,
                         HIGH_SIDE_DIRECT_IN};
            pin_sync <= pin_meta;
            fault_meta <= OUTPUT_FAULT;
            fault_sync <= fault_meta;
        end
    end

    assign cs_rise = cs_sync & ~cs_prev;
    assign commit = cs_rise & frame_ok & (tog_sync != tog_seen); // [R19]

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            tog_seen <= 1'b0;
        end else if (cs_rise) begin
            tog_seen <= tog_sync;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cfg <= {6{`SWCFG_CFG_RESET}}; // [R21]
        end else if (commit) begin
            case (frame_word.addr) // [R1]
                swcfg_pkg::SWCFG_ADDR_OUT_CMD: begin
                    cfg.out_cmd <= frame_word.data; // [R2]
                end
                swcfg_pkg::SWCFG_ADDR_DIRECT_EN: begin
                    cfg.direct_en <= frame_word.data; // [R3]
                end
                swcfg_pkg::SWCFG_ADDR_COMBINE: begin
                    cfg.combine <= frame_word.data; // [R4]
                end
                swcfg_pkg::SWCFG_ADDR_WDOG_SENSE: begin
                    cfg.wdog_sense <= frame_word.data; // [R5] [R7]
                end
                swcfg_pkg::SWCFG_ADDR_OPEN_LOAD: begin
                    cfg.open_load <= frame_word.data; // [R8] [R9]
                end
                swcfg_pkg::SWCFG_ADDR_CUR_LIMIT: begin
                    cfg.cur_limit <= frame_word.data; // [R10] [R11]
                end
                default: begin
                    // Unused and test addresses leave the configuration untouched [R12] [R13]
                end
            endcase
        end
    end

    // Echo of the service bit from the latest output-command frame
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            wd_echo <= 1'b0;
        end else if (commit && frame_word.addr == swcfg_pkg::SWCFG_ADDR_OUT_CMD) begin
            wd_echo <= frame_word.service; // [R15]
        end
    end

    // Any accepted frame carries a watchdog service bit
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            WATCHDOG_SERVICE_BIT <= 1'b0;
        end else if (commit) begin
            WATCHDOG_SERVICE_BIT <= frame_word.service; // [R1]
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            wrote_any <= 1'b0;
        end else if (commit) begin
            wrote_any <= 1'b1;
        end
    end

    // Faults stay latched; select rise drops only those already reported
    // and gone, so an event in the clearing cycle is never lost.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            fault_latch <= '0;
        end else if (cs_rise) begin
            fault_latch <= fault_sync | (fault_latch & ~status_word.fault); // [R20]
        end else begin
            fault_latch <= fault_latch | fault_sync; // [R17]
        end
    end

    always_comb begin
        if (wd_echo) begin
            next_pins = {pin_sync[2], pin_sync[3], pin_sync[6]}; // [R16]
        end else begin
            next_pins = {pin_sync[0], pin_sync[1], pin_sync[5]}; // [R16]
        end
    end

    // Tracks live state while select is high and freezes during the frame
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            status_word <= '0;
        end else if (cs_sync) begin
            status_word <= {wd_echo, next_pins, fault_latch}; // [R14] [R17]
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            HIGH_SIDE_OUTPUT <= '0;
            LOW_SIDE_OUTPUT <= '0;
        end else begin
            for (int i = 0; i < `SWCFG_HS_COUNT; i++) begin
                HIGH_SIDE_OUTPUT[i] <= drive_bit(cfg.out_cmd[i], cfg.direct_en[i],
                                                 cfg.combine[i], pin_sync[i]); // [R2]
            end
            for (int j = 0; j < `SWCFG_LS_COUNT; j++) begin
                LOW_SIDE_OUTPUT[j] <= drive_bit(cfg.out_cmd[j + `SWCFG_HS_COUNT],
                                                cfg.direct_en[j + `SWCFG_HS_COUNT],
                                                cfg.combine[j + `SWCFG_HS_COUNT],
                                                pin_sync[`SWCFG_HS_COUNT]); // [R2]
            end
        end
    end

    // Field outputs other than HS_OPEN_LOAD_EN are plain slices of the configuration flip-flops
    assign SENSE_OUT_PAIR_A_ROUTE = cfg.wdog_sense[`SWCFG_SENSE_A_LSB +: 2]; // [R7]
    assign SENSE_OUT_PAIR_B_ROUTE = cfg.wdog_sense[`SWCFG_SENSE_B_LSB +: 2]; // [R7]
    assign WDOG_TIMEOUT_DIV = swcfg_pkg::swcfg_wdt_div_t'(
        cfg.wdog_sense[`SWCFG_WDT_LSB +: 2]); // [R5]
    // Own flip-flop holding the inverse, so high-side detection is on by default
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            HS_OPEN_LOAD_EN <= `SWCFG_HS_OL_RESET; // [R21]
        end else if (commit && frame_word.addr == swcfg_pkg::SWCFG_ADDR_OPEN_LOAD) begin
            HS_OPEN_LOAD_EN <= ~frame_word.data[`SWCFG_HS_COUNT-1:0]; // [R8]
        end
    end

    assign LS_OPEN_LOAD_EN = cfg.open_load[`SWCFG_DATA_BITS-1:`SWCFG_HS_COUNT]; // [R9]
    assign HS_SUSTAIN_LIMIT = cfg.cur_limit[`SWCFG_HS_COUNT-1:0]; // [R10]
    assign LS_LATCH_OFF_EN = cfg.cur_limit[`SWCFG_DATA_BITS-1:`SWCFG_HS_COUNT]; // [R11]

    // ---------------- Checks ----------------
    AST_CFG_ZERO_UNTIL_WRITE: assert property ( // [R21]
        @(posedge REF_CLK) disable iff (RST)
        !wrote_any |-> (cfg == '0 && HS_OPEN_LOAD_EN == 4'hF && LS_OPEN_LOAD_EN == 8'h00))
        else $error("Configuration not zero before first write");

    AST_OUT_CMD_STORED: assert property ( // [R2]
        @(posedge REF_CLK) disable iff (RST)
        commit && frame_word.addr == swcfg_pkg::SWCFG_ADDR_OUT_CMD
        |=> cfg.out_cmd == $past(frame_word.data) && wd_echo == $past(frame_word.service))
        else $error("Output command frame not stored");

    AST_HS_OPEN_LOAD_INVERT: assert property ( // [R8]
        @(posedge REF_CLK) disable iff (RST)
        commit && frame_word.addr == swcfg_pkg::SWCFG_ADDR_OPEN_LOAD
        |=> HS_OPEN_LOAD_EN == ~$past(frame_word.data[3:0]))
        else $error("High-side open-load enable not inverse of written bits");

    AST_WDT_DIV_STORED: assert property ( // [R5]
        @(posedge REF_CLK) disable iff (RST)
        commit && frame_word.addr == swcfg_pkg::SWCFG_ADDR_WDOG_SENSE
        |=> WDOG_TIMEOUT_DIV == $past(frame_word.data[5:4]))
        else $error("Watchdog timeout code not stored");

    AST_DEAD_ADDR_NO_EFFECT: assert property ( // [R12] [R13]
        @(posedge REF_CLK) disable iff (RST)
        commit && frame_word.addr inside {swcfg_pkg::SWCFG_ADDR_UNUSED,
                                          swcfg_pkg::SWCFG_ADDR_TEST}
        |=> $stable(cfg) && $stable(wd_echo))
        else $error("Unused or test address changed configuration");

    AST_BAD_LENGTH_DROPPED: assert property ( // [R19]
        @(posedge REF_CLK) disable iff (RST)
        cs_rise && !frame_ok |=> $stable(cfg) && $stable(wd_echo))
        else $error("Frame of bad length was latched");

    AST_SERIAL_ONLY_PATH: assert property ( // [R3]
        @(posedge REF_CLK) disable iff (RST)
        cfg.direct_en[0] && $stable(cfg.out_cmd) && $stable(cfg.direct_en)
        |=> HIGH_SIDE_OUTPUT[0] == $past(cfg.out_cmd[0]))
        else $error("Output follows pin while direct control is off");

    AST_LS_AND_COMBINE: assert property ( // [R4]
        @(posedge REF_CLK) disable iff (RST)
        !cfg.direct_en[4] && cfg.combine[4] && !pin_sync[4]
        |=> !LOW_SIDE_OUTPUT[0])
        else $error("AND combine let output on with pin low");

    AST_STATUS_FROZEN: assert property ( // [R14]
        @(posedge REF_CLK) disable iff (RST)
        !cs_sync ##1 !cs_sync |-> $stable(status_word))
        else $error("Status word moved during a frame");

    AST_FAULT_STICKS: assert property ( // [R17]
        @(posedge REF_CLK) disable iff (RST)
        fault_sync[0] && !cs_rise ##1 !cs_rise [*3] |-> fault_latch[0])
        else $error("Latched fault lost without select rise");

    AST_ECHO_AFTER_STATUS: assert property ( // [R18]
        @(posedge SPI_SCLK) disable iff (link_rst)
        rise_cnt == `SWCFG_RISE_MAX ##1 rise_cnt == `SWCFG_RISE_MAX
        |-> so_shift == $past(rx_shift[`SWCFG_FRAME_BITS-1]))
        else $error("Received bits not echoed after status");

endmodule : swcfg_top

// File: tb/swcfg_master.sv
// Behavioural serial master that drives frames into the switch and captures its replies.
`timescale 1ns/1ps
module swcfg_master (
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    // Shift clock rests low and select rests high, as the pull-down and pull-up would leave them
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // Sends n bits MSB first and returns every bit seen on the data-out line
    task automatic send(input logic [31:0] tx, input int n, output logic [31:0] rx,
            output logic oe);
        rx = '0;
        oe = 1'b1;
        // Odd offset keeps the shift clock unrelated in phase to the core clock
        #1.3;
        cs_n = 1'b0;
        // Lead of several core cycles lets the status snapshot settle first
        #40;
        for (int i = n - 1; i >= 0; i--) begin
            // New data lands a nanosecond after the falling edge, never on it
            #1 si = tx[i];
            #2 sclk = 1'b1;
            #3 rx = {rx[30:0], so};
            oe = oe & so_oe;
            sclk = 1'b0;
        end
        #3 cs_n = 1'b1;
        // A released line must not look like a value that is still held
        si = ~si;
        #64;
    endtask : send
endmodule : swcfg_master

// File: tb/swcfg_top_tb.sv
// Self-checking bench for the switch configuration registers and status word.
`timescale 1ns/1ps
module swcfg_top_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic sclk;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    wire logic so_line;
    logic [3:0] hs_in = 4'h0;
    logic ls_in = 1'b0;
    logic failsafe_disable_pin = 1'b0;
    logic wake = 1'b0;
    logic [11:0] fault = 12'h000;
    logic [3:0] hs_out;
    logic [7:0] ls_out;
    logic [1:0] sense_a;
    logic [1:0] sense_b;
    swcfg_pkg::swcfg_wdt_div_t wdt;
    logic wd_svc;
    logic [3:0] hs_ol;
    logic [7:0] ls_ol;
    logic [3:0] hs_sus;
    logic [7:0] ls_lat;
    swcfg_pkg::swcfg_cfg_t cfg = '0;
    logic echo = 1'b0;
    logic svc = 1'b0;
    logic [11:0] lat = 12'h000;
    logic [31:0] seed = 32'h42;
    int miscompares = 0;
    int check_count = 0;

    always #4 ref_clk = ~ref_clk;

    // Nobody drives the line while the device floats it
    assign so_line = so_oe ? so : 1'bz;

    swcfg_top swcfg_top_i (
        .REF_CLK(ref_clk), .RST(rst), .SPI_SCLK(sclk), .CHIP_SELECT_N(cs_n), .SPI_SI(si),
        .SPI_SO(so), .SPI_SO_OE(so_oe), .HIGH_SIDE_DIRECT_IN(hs_in),
        .LOW_SIDE_DIRECT_IN(ls_in), .FAILSAFE_DISABLE_PIN(failsafe_disable_pin), .WAKE_PIN(wake),
        .OUTPUT_FAULT(fault), .HIGH_SIDE_OUTPUT(hs_out), .LOW_SIDE_OUTPUT(ls_out),
        .SENSE_OUT_PAIR_A_ROUTE(sense_a), .SENSE_OUT_PAIR_B_ROUTE(sense_b),
        .WDOG_TIMEOUT_DIV(wdt), .WATCHDOG_SERVICE_BIT(wd_svc), .HS_OPEN_LOAD_EN(hs_ol),
        .LS_OPEN_LOAD_EN(ls_ol), .HS_SUSTAIN_LIMIT(hs_sus), .LS_LATCH_OFF_EN(ls_lat)
    );

    swcfg_master swcfg_master_i (
        .sclk(sclk), .cs_n(cs_n), .si(si), .so(so_line), .so_oe(so_oe)
    );

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    function automatic logic [11:0] exp_drive(input swcfg_pkg::swcfg_cfg_t c,
            input logic [3:0] h, input logic l);
        logic [11:0] pin;
        logic [11:0] mix;
        // Every low-side output shares the one low-side pin
        pin = {{8{l}}, h};
        mix = (c.combine & c.out_cmd & pin) | (~c.combine & (c.out_cmd | pin));
        return (c.direct_en & c.out_cmd) | (~c.direct_en & mix);
    endfunction : exp_drive

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t ns: seen %h, expected %h", $realtime, seen, exp);
        end
    endtask : check

    task automatic check_cfg();
        check({ls_out, hs_out}, exp_drive(cfg, hs_in, ls_in));
        check({sense_b, sense_a}, cfg.wdog_sense[3:0]);
        check(wdt, cfg.wdog_sense[5:4]);
        check({ls_ol, hs_ol}, {cfg.open_load[11:4], ~cfg.open_load[3:0]});
        check({ls_lat, hs_sus}, cfg.cur_limit);
        check(wd_svc, svc);
        check(so_oe, 1'b0);
    endtask : check_cfg

    task automatic frame(input logic [31:0] tx, input int n);
        logic [31:0] rx;
        logic oe;
        logic [15:0] w;
        logic [15:0] st;
        st = {echo, echo ? {hs_in[2], hs_in[3], wake} : {hs_in[0], hs_in[1], failsafe_disable_pin}, lat};
        swcfg_master_i.send(tx, n, rx, oe);
        check(rx >> (n - 16), st);
        check(rx & ((32'h1 << (n - 16)) - 32'h1), tx >> 16);
        check(oe, 1'b1);
        // Fault inputs held through the frame, so only live faults stay latched
        lat = fault;
        w = tx[15:0];
        if (n % 16 == 0) begin
            svc = w[15];
            case (swcfg_pkg::swcfg_addr_t'(w[14:12]))
                swcfg_pkg::SWCFG_ADDR_OUT_CMD: begin
                    cfg.out_cmd = w[11:0];
                    echo = w[15];
                end
                swcfg_pkg::SWCFG_ADDR_DIRECT_EN: cfg.direct_en = w[11:0];
                swcfg_pkg::SWCFG_ADDR_COMBINE: cfg.combine = w[11:0];
                swcfg_pkg::SWCFG_ADDR_WDOG_SENSE: cfg.wdog_sense = w[11:0];
                swcfg_pkg::SWCFG_ADDR_OPEN_LOAD: cfg.open_load = w[11:0];
                swcfg_pkg::SWCFG_ADDR_CUR_LIMIT: cfg.cur_limit = w[11:0];
                default: ;
            endcase
        end
        check_cfg();
    endtask : frame

    task automatic summarize();
        $display("comparisons %0d, miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #100000;
        miscompares++;
        summarize();
    end

    initial begin
        int lens[4];
        logic [31:0] r;
        logic [31:0] tx;
        logic [15:0] word;
        logic [31:0] rnd;
        // Valid lengths and one bit short or over a whole word
        lens = '{16, 32, 17, 31};
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        repeat (8) @(negedge ref_clk);
        check_cfg();
        for (int i = 0; i < 32; i++) begin
            r = xorshift();
            @(negedge ref_clk);
            {hs_in, ls_in, failsafe_disable_pin, wake} = r[6:0];
            fault = r[18:7];
            lat |= fault;
            repeat (4) @(negedge ref_clk);
            check_cfg();
            rnd = xorshift();
            word = {r[31], 3'(i % 8), rnd[11:0]};
            if (i % 8 == 6) begin
                word[15] = ~svc;
            end
            rnd = xorshift();
            tx = {rnd[15:0], word};
            if (lens[i / 8] < 32) begin
                tx &= (32'h1 << lens[i / 8]) - 32'h1;
            end
            frame(tx, lens[i / 8]);
        end
        // Reset in mid-run must bring every setting back to its idle value
        @(negedge ref_clk) rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        cfg = '0;
        svc = 1'b0;
        echo = 1'b0;
        // Faults still present come straight back into the cleared latch
        lat = fault;
        repeat (8) @(negedge ref_clk);
        check_cfg();
        frame(32'h0000_4A5C, 16);
        summarize();
    end
endmodule : swcfg_top_tb
